// ### src/cfg_dma_params.svh
// constants for the configuration dma register block
// assumes inclusion by bare name from src/
`ifndef CFG_DMA_PARAMS_SVH
`define CFG_DMA_PARAMS_SVH
// ==========================================================
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_ADDR 12'h004
`define OFS_COUNT 12'h008
`define OFS_HEADER 12'h00c
`define OFS_FLAGS 12'h010
`define OFS_MASK 12'h014
`define OFS_WAIT 12'h018
// ==========================================================
// control field positions
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_TO_HDR 2
`define CTRL_HSEL 3
`define CTRL_HTRANS0 4
`define CTRL_HTRANS1 5
`define CTRL_HREADY 6
`define CTRL_XFR_PEND 7
`define CTRL_BRG_PEND 8
// ==========================================================
// flag positions
`define FLG_HERR 0
`define FLG_RXAV 1
`define FLG_BOVF 2
`define FLG_SPIM_LO 3
// ==========================================================
// reset values and count width
`define RST_MASK 3'h7
`define RST_WAIT 16'h01f4
`define RST_HREADY 1'b1
`define CNT_W 26
// ==========================================================
// answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### src/cfg_dma_pkg.sv
// types for the configuration dma register block
// assumes cfg_dma_params.svh alongside
package cfg_dma_pkg;
   // ==========================================================
   // engine sequence
   typedef enum logic [2:0] {
      ENG_IDLE = 3'b001,
      ENG_REQ = 3'b010,
      ENG_WAIT = 3'b100
   } eng_state_t;
endpackage

// ### src/frame_engine_if.sv
// carrier between register block and frame mover
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface frame_engine_if;
   logic enable;
   logic to_header;
   logic [31:0] dest_addr;
   logic [25:0] last_index;
   logic stop;
   logic frame_done;
   logic run_done;
   logic ahb_err;
   logic [31:0] ahb_addr;
   logic ahb_write;
   logic xfr_pending;
   modport regs (output enable, to_header, dest_addr, last_index, stop,
      input frame_done, run_done, ahb_err, ahb_addr, ahb_write, xfr_pending);
   modport engine (input enable, to_header, dest_addr, last_index, stop,
      output frame_done, run_done, ahb_err, ahb_addr, ahb_write, xfr_pending);
endinterface
`default_nettype wire

// ### src/frame_mover.sv
// frame mover: counts frames from the spi source to ahb or header
// assumes frames arrive as a valid strobe, ahb beats acked by hready
`timescale 1ns/1ps
`default_nettype none
module frame_mover (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // frame source
   input wire logic frame_valid_i,
   // ahb master status
   input wire logic hready_i,
   input wire logic hresp_i,
   // register side
   frame_engine_if.engine eng
);
   // ==========================================================
   // state
   typedef struct packed {
      cfg_dma_pkg::eng_state_t st;
      logic [25:0] index;
      logic [31:0] addr;
   } mover_t;
   mover_t s_q, s_d;

   // sequence: wait frame, issue beat, wait hready
   always_comb begin
      s_d = s_q;
      eng.frame_done = 1'b0;
      eng.run_done = 1'b0;
      eng.ahb_err = 1'b0;
      case (s_q.st)
         cfg_dma_pkg::ENG_IDLE: begin
            if (eng.enable && frame_valid_i) begin
               s_d.st = cfg_dma_pkg::ENG_REQ;
            end
         end
         cfg_dma_pkg::ENG_REQ: begin
            // header steering skips the bus entirely
            if (eng.to_header) begin
               eng.frame_done = 1'b1;
               s_d.st = cfg_dma_pkg::ENG_IDLE;
            end else begin
               s_d.st = cfg_dma_pkg::ENG_WAIT;
            end
         end
         cfg_dma_pkg::ENG_WAIT: begin
            if (hready_i) begin
               eng.frame_done = 1'b1;
               eng.ahb_err = hresp_i;
               s_d.addr = s_q.addr + 32'h0000_0001;
               s_d.st = cfg_dma_pkg::ENG_IDLE;
            end
         end
         default: s_d.st = cfg_dma_pkg::ENG_IDLE;
      endcase
      if (eng.frame_done) begin
         // count plus one frames in total
         if (s_q.index == eng.last_index) begin
            eng.run_done = 1'b1;
            s_d.index = 26'h000_0000;
         end else begin
            s_d.index = s_q.index + 26'h000_0001;
         end
      end
      // disabled idle engine tracks the programmed start address
      if (!eng.enable && s_q.st == cfg_dma_pkg::ENG_IDLE) begin
         s_d.addr = eng.dest_addr;
         s_d.index = 26'h000_0000;
      end
      if (eng.stop) begin
         s_d.st = cfg_dma_pkg::ENG_IDLE;
         s_d.index = 26'h000_0000;
      end
   end

   assign eng.ahb_addr = s_q.addr;
   assign eng.ahb_write = (s_q.st == cfg_dma_pkg::ENG_WAIT);
   assign eng.xfr_pending = (s_q.st != cfg_dma_pkg::ENG_IDLE);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{st: cfg_dma_pkg::ENG_IDLE, index: 26'h000_0000,
            addr: 32'h0000_0000};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// ### src/cfg_dma_regs.sv
// configuration dma register block with axi4-lite slave
// What this block does
// - registers 0x0-0xc blocked while engine or sequencer holds mux.
// - control bit 0 write one enables engine; reads enable.
// - control bit 1 write one stops, clears done; reads done.
// - control bit 2 steers data to ahb or header register.
// - control bits 3-6 mirror hsel, htrans, hready; hready resets one.
// - bit 7 engine pending, bit 8 bridge pending.
// - 32-bit destination address, reset zero.
// - count field holds frames minus one; engine moves count plus one.
// - header low 16 bits give boot size in 8-byte units minus one.
// - header bits 23:16 give spi clock divider.
// - header top byte gives part code; header resets zero.
// - flag 0 sets on ahb error, write one clears.
// - flag 1 read-only raw receive threshold.
// - flag 2 sets on bridge fifo overflow, write one clears.
// - flags 3-8 mirror spi master interrupts.
// - mask bits 0-2 keep flags 0-2 off the interrupt, reset to one.
// - 16-bit sequencer wait interval, reset 500 pclk cycles.
// assumes one clock, axi4-lite master, spi and ahb status at the pins
`timescale 1ns/1ps
`default_nettype none
`include "cfg_dma_params.svh"
module cfg_dma_regs (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // axi4-lite write
   input wire logic [11:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // axi4-lite read
   input wire logic [11:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // mux ownership
   input wire logic SEQ_MUX_SEL_I,
   // frame source and header capture
   input wire logic FRAME_VALID_I,
   input wire logic [7:0] FRAME_DATA_I,
   // ahb master status
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HREADY_I,
   input wire logic HRESP_I,
   input wire logic BRIDGE_PENDING_I,
   input wire logic BRIDGE_OVERFLOW_I,
   // spi master interrupts, receive threshold first
   input wire logic RX_THRESH_I,
   input wire logic [5:0] SPIM_INTR_I,
   // outputs to the rest of the system
   output logic [31:0] AHB_ADDR_O,
   output logic AHB_WRITE_O,
   output logic [15:0] SEQ_WAIT_O,
   output logic IRQ_O
);
   // ==========================================================
   // state
   typedef struct packed {
      logic enable;
      logic done;
      logic to_header;
      logic [31:0] dest;
      logic [25:0] count;
      logic [31:0] header;
      logic herr;
      logic bovf;
      logic [2:0] mask;
      logic [15:0] wait_ival;
      logic hready_seen;
      logic aw_got;
      logic w_got;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } regs_t;
   regs_t s_q, s_d;

   frame_engine_if eng_if();
   logic mux_busy;
   logic do_write;
   logic do_read;
   logic [31:0] wmask;
   logic [31:0] ctrl_rd;
   logic [31:0] flag_rd;

   // ==========================================================
   // frame mover
   frame_mover frame_mover_inst (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .frame_valid_i(FRAME_VALID_I),
      .hready_i(HREADY_I),
      .hresp_i(HRESP_I),
      .eng(eng_if.engine)
   );

   assign eng_if.enable = s_q.enable;
   assign eng_if.to_header = s_q.to_header;
   assign eng_if.dest_addr = s_q.dest;
   assign eng_if.last_index = s_q.count;
   // a software write of control bit 1 ends the run
   assign eng_if.stop = do_write && s_q.aw_addr == `OFS_CTRL
      && s_q.w_strb[0] && s_q.w_data[`CTRL_STOP] && !mux_busy;

   // mux held by our engine or by the sequencer
   assign mux_busy = eng_if.xfr_pending || SEQ_MUX_SEL_I;

   // ==========================================================
   // read views
   always_comb begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[`CTRL_START] = s_q.enable;
      ctrl_rd[`CTRL_STOP] = s_q.done;
      ctrl_rd[`CTRL_TO_HDR] = s_q.to_header;
      ctrl_rd[`CTRL_HSEL] = HSEL_I;
      ctrl_rd[`CTRL_HTRANS0] = HTRANS_I[0];
      ctrl_rd[`CTRL_HTRANS1] = HTRANS_I[1];
      // inputs are unknown during reset, so hready shows one until seen
      ctrl_rd[`CTRL_HREADY] = s_q.hready_seen ? HREADY_I : `RST_HREADY;
      ctrl_rd[`CTRL_XFR_PEND] = eng_if.xfr_pending;
      ctrl_rd[`CTRL_BRG_PEND] = BRIDGE_PENDING_I;
      flag_rd = 32'h0000_0000;
      flag_rd[`FLG_HERR] = s_q.herr;
      flag_rd[`FLG_RXAV] = RX_THRESH_I;
      flag_rd[`FLG_BOVF] = s_q.bovf;
      flag_rd[`FLG_SPIM_LO +: 6] = SPIM_INTR_I;
   end

   // byte lanes into a bit mask
   always_comb begin
      wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
         {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
   end

   assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign do_read = ARVALID_I && !s_q.rvalid;

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.hready_seen = 1'b1;
      // address and data taken in either order
      if (AWVALID_I && !s_q.aw_got) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = {AWADDR_I[11:2], 2'b00};
      end
      if (WVALID_I && !s_q.w_got) begin
         s_d.w_got = 1'b1;
         s_d.w_data = WDATA_I;
         s_d.w_strb = WSTRB_I;
      end
      if (s_q.bvalid && BREADY_I) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && RREADY_I) begin
         s_d.rvalid = 1'b0;
      end

      // header capture in place of bus writes
      // byte taken with its accepted strobe: the lane is gone a cycle later
      if (FRAME_VALID_I && s_q.enable && s_q.to_header
            && !eng_if.xfr_pending && !eng_if.stop) begin
         s_d.header = {FRAME_DATA_I, s_q.header[31:8]};
      end
      if (eng_if.run_done) begin
         s_d.enable = 1'b0;
         s_d.done = 1'b1;
      end

      // register writes
      if (do_write) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         case (s_q.aw_addr)
            `OFS_CTRL: begin
               if (mux_busy) begin
                  s_d.bresp = `RESP_SLVERR;
               end else if (s_q.w_strb[0]) begin
                  if (s_q.w_data[`CTRL_START]) begin
                     s_d.enable = 1'b1;
                  end
                  if (s_q.w_data[`CTRL_STOP]) begin
                     s_d.enable = 1'b0;
                     s_d.done = 1'b0;
                  end
                  s_d.to_header = s_q.w_data[`CTRL_TO_HDR];
               end
            end
            `OFS_ADDR: begin
               if (mux_busy) begin
                  s_d.bresp = `RESP_SLVERR;
               end else begin
                  s_d.dest = (s_q.dest & ~wmask) | (s_q.w_data & wmask);
               end
            end
            `OFS_COUNT: begin
               if (mux_busy) begin
                  s_d.bresp = `RESP_SLVERR;
               end else begin
                  s_d.count = (s_q.count & ~wmask[25:0])
                     | (s_q.w_data[25:0] & wmask[25:0]);
               end
            end
            `OFS_HEADER: begin
               if (mux_busy) begin
                  s_d.bresp = `RESP_SLVERR;
               end
            end
            `OFS_FLAGS: begin
               if (s_q.w_strb[0]) begin
                  if (s_q.w_data[`FLG_HERR]) begin
                     s_d.herr = 1'b0;
                  end
                  if (s_q.w_data[`FLG_BOVF]) begin
                     s_d.bovf = 1'b0;
                  end
               end
            end
            `OFS_MASK: begin
               if (s_q.w_strb[0]) begin
                  s_d.mask = s_q.w_data[2:0];
               end
            end
            `OFS_WAIT: begin
               s_d.wait_ival = (s_q.wait_ival & ~wmask[15:0])
                  | (s_q.w_data[15:0] & wmask[15:0]);
            end
            default: s_d.bresp = `RESP_SLVERR;
         endcase
      end

      // set wins over a clear in the same cycle
      if (eng_if.ahb_err) begin
         s_d.herr = 1'b1;
      end
      if (BRIDGE_OVERFLOW_I) begin
         s_d.bovf = 1'b1;
      end

      // register reads
      if (do_read) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         case ({ARADDR_I[11:2], 2'b00})
            `OFS_CTRL: s_d.rdata = ctrl_rd;
            `OFS_ADDR: s_d.rdata = s_q.dest;
            `OFS_COUNT: s_d.rdata = {6'h00, s_q.count};
            `OFS_HEADER: s_d.rdata = s_q.header;
            `OFS_FLAGS: s_d.rdata = flag_rd;
            `OFS_MASK: s_d.rdata = {29'h0000_0000, s_q.mask};
            `OFS_WAIT: s_d.rdata = {16'h0000, s_q.wait_ival};
            default: s_d.rresp = `RESP_SLVERR;
         endcase
         // blocked registers answer an error with zero data
         if (mux_busy && ({ARADDR_I[11:2], 2'b00} == `OFS_CTRL
               || {ARADDR_I[11:2], 2'b00} == `OFS_ADDR
               || {ARADDR_I[11:2], 2'b00} == `OFS_COUNT
               || {ARADDR_I[11:2], 2'b00} == `OFS_HEADER)) begin
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = `RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s_q <= '0;
         s_q.mask <= `RST_MASK;
         s_q.wait_ival <= `RST_WAIT;
      end else if (CE_I) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign AWREADY_O = !s_q.aw_got;
   assign WREADY_O = !s_q.w_got;
   assign BVALID_O = s_q.bvalid;
   assign BRESP_O = s_q.bresp;
   assign ARREADY_O = !s_q.rvalid;
   assign RVALID_O = s_q.rvalid;
   assign RDATA_O = s_q.rdata;
   assign RRESP_O = s_q.rresp;
   assign AHB_ADDR_O = eng_if.ahb_addr;
   assign AHB_WRITE_O = eng_if.ahb_write;
   assign SEQ_WAIT_O = s_q.wait_ival;
   // raw flags gated by mask
   assign IRQ_O = |({s_q.bovf, RX_THRESH_I, s_q.herr} & ~s_q.mask);
endmodule
`default_nettype wire

// ### verif/cfg_dma_monitor.sv
// checker for the configuration dma register block
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cfg_dma_monitor (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // register bus
   input wire logic WVALID_I,
   input wire logic [11:0] ARADDR_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0] RRESP_O,
   input wire logic RVALID_O,
   // status inputs
   input wire logic SEQ_MUX_SEL_I,
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HREADY_I,
   input wire logic HRESP_I,
   input wire logic BRIDGE_PENDING_I,
   input wire logic BRIDGE_OVERFLOW_I,
   input wire logic RX_THRESH_I,
   input wire logic [5:0] SPIM_INTR_I,
   // outputs
   input wire logic [31:0] AHB_ADDR_O,
   input wire logic AHB_WRITE_O,
   input wire logic [15:0] SEQ_WAIT_O,
   input wire logic IRQ_O
);
   // ==========================================================
   // one domain, so clock and reset are given once
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   logic ar_take;
   // read address accepted at this edge
   assign ar_take = ARVALID_I && ARREADY_O && CE_I;
   // ==========================================================
   // assertions
   read_answer_a: assert property (ar_take |=> RVALID_O)
      else $error("read not answered one cycle after address");
   mux_block_a: assert property (
      ar_take && SEQ_MUX_SEL_I && ARADDR_I < 12'h010
      |=> RRESP_O == 2'h2 && RDATA_O == 32'h0000_0000)
      else $error("blocked read not refused");
   ctrl_mirror_a: assert property (
      ar_take && ARADDR_I == 12'h000 |=> RRESP_O != 2'h0 ||
      (RDATA_O[6:3] == {$past(HREADY_I), $past(HTRANS_I), $past(HSEL_I)}
      && RDATA_O[8] == $past(BRIDGE_PENDING_I)))
      else $error("control status bits differ from bus levels");
   flag_mirror_a: assert property (
      ar_take && ARADDR_I == 12'h010 |=> RRESP_O == 2'h0 &&
      RDATA_O[1] == $past(RX_THRESH_I) &&
      RDATA_O[8:3] == $past(SPIM_INTR_I))
      else $error("live flags differ from their inputs");
   wait_reset_a: assert property (
      $fell(RST_I) |-> SEQ_WAIT_O == 16'h01f4)
      else $error("wait interval not at its reset value");
   irq_reset_a: assert property ($fell(RST_I) |-> !IRQ_O)
      else $error("interrupt high straight after reset");
   irq_cause_a: assert property (
      $rose(IRQ_O) |-> $past(WVALID_I) || $past(WVALID_I, 2) ||
      $past(HRESP_I) || $past(BRIDGE_OVERFLOW_I) || RX_THRESH_I ||
      $past(RX_THRESH_I))
      else $error("interrupt rose without a cause");
   beat_hold_a: assert property (
      AHB_WRITE_O && !HREADY_I |=> AHB_WRITE_O && $stable(AHB_ADDR_O))
      else $error("ahb beat dropped before hready");
   addr_step_a: assert property (
      AHB_WRITE_O && HREADY_I && CE_I |=>
      AHB_ADDR_O == $past(AHB_ADDR_O) + 32'h0000_0001)
      else $error("ahb address did not step after a beat");
endmodule
bind cfg_dma_regs cfg_dma_monitor cfg_dma_monitor_inst (
   .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I),
   .WVALID_I(WVALID_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
   .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
   .RVALID_O(RVALID_O), .SEQ_MUX_SEL_I(SEQ_MUX_SEL_I), .HSEL_I(HSEL_I),
   .HTRANS_I(HTRANS_I), .HREADY_I(HREADY_I), .HRESP_I(HRESP_I),
   .BRIDGE_PENDING_I(BRIDGE_PENDING_I),
   .BRIDGE_OVERFLOW_I(BRIDGE_OVERFLOW_I), .RX_THRESH_I(RX_THRESH_I),
   .SPIM_INTR_I(SPIM_INTR_I), .AHB_ADDR_O(AHB_ADDR_O),
   .AHB_WRITE_O(AHB_WRITE_O), .SEQ_WAIT_O(SEQ_WAIT_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### verif/frame_partner.sv
// frame source and ahb slave model facing the dma engine
// assumes the bench calls send, one run at a time
`timescale 1ns/1ps
`default_nettype none
module frame_partner (
   // clock
   input wire logic clk_i,
   // frame source
   output logic frame_valid_o,
   output logic [7:0] frame_data_o,
   // ahb slave answer
   output logic hready_o,
   output logic hresp_o
);
   // ==========================================================
   // idle: no frame, slave ready, okay answer
   initial begin
      frame_valid_o = 1'b0;
      frame_data_o = 8'h00;
      hready_o = 1'b1;
      hresp_o = 1'b0;
   end
   // a slow slave holds hready low for stall plus one cycles per frame
   task automatic send(input int n, input logic [7:0] first,
      input int stall, input logic err);
      int i;
      for (i = 0; i < n && i < 65536; i++) begin
         @(posedge clk_i);
         frame_valid_o <= 1'b1;
         frame_data_o <= first + i[7:0];
         hready_o <= (stall == 0);
         @(posedge clk_i);
         frame_valid_o <= 1'b0;
         // released byte lane shows the inverse, not a stale value
         frame_data_o <= ~(first + i[7:0]);
         repeat (stall) @(posedge clk_i);
         hready_o <= 1'b1;
         hresp_o <= err && (i == n - 1);
         @(posedge clk_i);
         hresp_o <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// ### verif/cfg_dma_regs_test.sv
// self-checking bench for the configuration dma register block
// assumes design, frame partner and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module cfg_dma_regs_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, mux_sel = 1'b0;
   logic hsel = 1'b0, br_pend = 1'b0, br_ovf = 1'b0, rx_thr = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [5:0] spim = 6'h00;
   logic awready, wready, bvalid, arready, rvalid, irq, ahb_write;
   logic fvalid, hready, hresp;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, ahb_addr, rd;
   logic [7:0] fdata;
   logic [15:0] seq_wait;
   int errors = 0;
   int compares = 0;
   // 125 MHz system clock
   always #4 clk = ~clk;
   // ==========================================================
   // design and far-side model
   cfg_dma_regs cfg_dma_regs_inst (.CLK_SYS_I(clk), .RST_I(rst),
      .CE_I(1'b1), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf),
      .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
      .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .SEQ_MUX_SEL_I(mux_sel), .FRAME_VALID_I(fvalid),
      .FRAME_DATA_I(fdata), .HSEL_I(hsel), .HTRANS_I(htrans),
      .HREADY_I(hready), .HRESP_I(hresp), .BRIDGE_PENDING_I(br_pend),
      .BRIDGE_OVERFLOW_I(br_ovf), .RX_THRESH_I(rx_thr),
      .SPIM_INTR_I(spim), .AHB_ADDR_O(ahb_addr),
      .AHB_WRITE_O(ahb_write), .SEQ_WAIT_O(seq_wait), .IRQ_O(irq));
   frame_partner frame_partner_inst (.clk_i(clk), .frame_valid_o(fvalid),
      .frame_data_o(fdata), .hready_o(hready), .hresp_o(hresp));
   // ==========================================================
   // verdict, comparison and bus tasks
   task automatic results;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // outputs read right after the edge still hold their sampled values
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      if (n == 200) begin
         errors++;
         results;
      end
   endtask
   task automatic rd_t(input logic [11:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
      if (n == 200) begin
         errors++;
         results;
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] er);
      rd_t(a);
      chk("rdata", rd, e);
      chk("rresp", {30'h0, rr}, {30'h0, er});
   endtask
   // engine holds the mux while busy, so poll until control answers
   task automatic wait_idle;
      int n;
      for (n = 0; n < 50; n++) begin
         rd_t(12'h000);
         if (rr == 2'h0) break;
      end
      if (n == 50) begin
         errors++;
         results;
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(12'h004, 32'h0000_0000, 2'h0);
      rc(12'h00c, 32'h0000_0000, 2'h0);
      rc(12'h014, 32'h0000_0007, 2'h0);
      rc(12'h018, 32'h0000_01f4, 2'h0);
      wr(12'h004, 32'h1234_5678, 2'h0);
      wr(12'h008, 32'hffff_ffff, 2'h0);
      rc(12'h008, 32'h03ff_ffff, 2'h0);
      wr(12'h018, 32'hffff_0010, 2'h0);
      rc(12'h018, 32'h0000_0010, 2'h0);
      chk("wait", {16'h0, seq_wait}, 32'h0000_0010);
      wr(12'h00c, 32'hffff_ffff, 2'h0);
      rc(12'h00c, 32'h0000_0000, 2'h0);
      wr(12'h01c, 32'h0000_0001, 2'h2);
      rc(12'h01c, 32'h0000_0000, 2'h2);
      // sequencer owns the mux: engine registers refuse
      mux_sel <= 1'b1;
      wr(12'h004, 32'h0000_00ff, 2'h2);
      rc(12'h004, 32'h0000_0000, 2'h2);
      rc(12'h014, 32'h0000_0007, 2'h0);
      mux_sel <= 1'b0;
      rc(12'h004, 32'h1234_5678, 2'h0);
      // four frames into the boot header
      wr(12'h008, 32'h0000_0003, 2'h0);
      wr(12'h000, 32'h0000_0005, 2'h0);
      frame_partner_inst.send(4, 8'ha1, 0, 1'b0);
      wait_idle;
      rc(12'h00c, 32'ha4a3_a2a1, 2'h0);
      rc(12'h000, 32'h0000_0046, 2'h0);
      wr(12'h000, 32'h0000_0002, 2'h0);
      rc(12'h000, 32'h0000_0040, 2'h0);
      // overflow while masked, then unmask and clear
      br_ovf <= 1'b1;
      @(posedge clk);
      br_ovf <= 1'b0;
      rc(12'h010, 32'h0000_0004, 2'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(12'h014, 32'h0000_0000, 2'h0);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(12'h010, 32'h0000_0004, 2'h0);
      rc(12'h010, 32'h0000_0000, 2'h0);
      // two frames to ahb, slow slave, error on the last beat
      wr(12'h004, 32'h0000_0100, 2'h0);
      wr(12'h008, 32'h0000_0001, 2'h0);
      wr(12'h000, 32'h0000_0001, 2'h0);
      frame_partner_inst.send(2, 8'h11, 3, 1'b1);
      wait_idle;
      // stopped engine reloads the start address; steps checked by monitor
      chk("addr", ahb_addr, 32'h0000_0100);
      rc(12'h000, 32'h0000_0042, 2'h0);
      rc(12'h00c, 32'ha4a3_a2a1, 2'h0);
      rc(12'h010, 32'h0000_0001, 2'h0);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(12'h010, 32'h0000_0001, 2'h0);
      rc(12'h010, 32'h0000_0000, 2'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      // live status mirrors
      wr(12'h014, 32'h0000_0007, 2'h0);
      hsel <= 1'b1;
      htrans <= 2'b10;
      br_pend <= 1'b1;
      rx_thr <= 1'b1;
      spim <= 6'h21;
      rc(12'h000, 32'h0000_016a, 2'h0);
      rc(12'h010, 32'h0000_010a, 2'h0);
      hsel <= 1'b0;
      htrans <= 2'b01;
      br_pend <= 1'b0;
      rx_thr <= 1'b0;
      spim <= 6'h1e;
      rc(12'h000, 32'h0000_0052, 2'h0);
      rc(12'h010, 32'h0000_00f0, 2'h0);
      results;
   end
endmodule
`default_nettype wire
